// file: dv/rmg_checker.sv
`timescale 1ns/1ps
module rmg_checker
	import rmg_pkg::*;
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        restart_done,
	input wire logic        frame_done,
	input wire logic        all_rows_int,
	input wire logic        row_valid,
	input wire logic [15:0] row_period,
	input wire logic        capture_start,
	input wire logic        capture_busy,
	input wire logic        frame_restart,
	input wire logic        col_skip4,
	input wire logic        row_skip8,
	input wire logic        flash_strobe
);
	logic [15:0] ctl;
	logic        wc;
	logic        wr0;
	// shadow of the control word so strobe modes can be judged
	assign wc = reg_wr && reg_addr == RMG_ADDR_READ_CTL;
	assign wr0 = reg_wr && reg_addr == RMG_ADDR_RESTART && reg_wdata[0];
	always_ff @(posedge mclk) begin
		if (sys_rst) ctl <= 16'h8000;
		else if (wc) ctl <= reg_wdata;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_col; wc |-> ##2 col_skip4 == $past(reg_wdata[2], 2); endproperty
	a_col: assert property (p_col) else $error("column skip copy wrong");
	property p_row; wc |-> ##2 row_skip8 == $past(reg_wdata[5], 2); endproperty
	a_row: assert property (p_row) else $error("row skip copy wrong");
	property p_one; capture_start |=> !capture_start && capture_busy; endproperty
	a_one: assert property (p_one) else $error("start not a single pulse");
	property p_end; frame_done && capture_busy && !capture_start |=> !capture_busy; endproperty
	a_end: assert property (p_end) else $error("busy held past frame end");
	property p_set; wr0 |=> frame_restart; endproperty
	a_set: assert property (p_set) else $error("restart not pending");
	property p_clr; frame_restart && restart_done && !wr0 |=> !frame_restart; endproperty
	a_clr: assert property (p_clr) else $error("restart not cleared");
	property p_off; !ctl[9] && !ctl[11] |=> !flash_strobe; endproperty
	a_off: assert property (p_off) else $error("strobe while disabled");
	property p_ovr; ctl[11] |=> flash_strobe; endproperty
	a_ovr: assert property (p_ovr) else $error("override ignored");
	property p_wide; ctl[9] && ctl[10] && !ctl[11] |=> flash_strobe == $past(all_rows_int); endproperty
	a_wide: assert property (p_wide) else $error("wide strobe wrong");
	property p_cut; ctl[9] && !ctl[10] && !ctl[11] && row_valid |=> !flash_strobe; endproperty
	a_cut: assert property (p_cut) else $error("strobe into row valid");
	property p_rise; ctl[9] && !ctl[11] && all_rows_int && !$past(all_rows_int) && !row_valid
		&& row_period != 16'h0000 |=> flash_strobe; endproperty
	a_rise: assert property (p_rise) else $error("strobe did not start");
	property p_rd; reg_rd && reg_addr == RMG_ADDR_READ_CTL |=> reg_rdata == $past(ctl); endproperty
	a_rd: assert property (p_rd) else $error("control readback wrong");
endmodule : rmg_checker
bind rmg_readout_ctrl rmg_checker i_chk (
	.mclk          (mclk),
	.sys_rst       (sys_rst),
	.reg_addr      (reg_addr),
	.reg_wdata     (reg_wdata),
	.reg_wr        (reg_wr),
	.reg_rd        (reg_rd),
	.reg_rdata     (reg_rdata),
	.restart_done  (restart_done),
	.frame_done    (frame_done),
	.all_rows_int  (all_rows_int),
	.row_valid     (row_valid),
	.row_period    (row_period),
	.capture_start (capture_start),
	.capture_busy  (capture_busy),
	.frame_restart (frame_restart),
	.col_skip4     (col_skip4),
	.row_skip8     (row_skip8),
	.flash_strobe  (flash_strobe)
);

// file: dv/rmg_core_model.sv
`timescale 1ns/1ps
module rmg_core_model
	import rmg_pkg::*;
#(
	parameter int FRAME = 6
)
(
	input  wire logic mclk,
	input  wire logic capture_start,
	input  wire logic frame_restart,
	output logic      restart_done,
	output logic      frame_done
);
	int cnt = 0;
	// no reset: the count idles at zero until a capture starts; both outputs settle at the first edge
	always @(posedge mclk) begin
		restart_done <= frame_restart && cnt == 2;
		frame_done <= cnt == FRAME;
		cnt <= capture_start ? 1 : (cnt != 0 && cnt < FRAME) ? cnt + 1 : 0;
	end
endmodule : rmg_core_model

// file: dv/tb.sv
`timescale 1ns/1ps
module tb
	import rmg_pkg::*;
;
	logic        mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, trigger_pin = 0;
	logic [7:0]  reg_addr = 8'h00, pix_gain;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, row_period = 16'h0004;
	logic        all_rows_int = 0, row_valid = 0, pix_row_odd = 0, pix_col_odd = 0;
	logic        restart_done, frame_done, capture_start, capture_busy, frame_restart;
	logic        col_skip4, col_skip8, row_skip4, row_skip8, flash_strobe;
	int          fail_count = 0, compares = 0, cycles = 0;
	initial forever #12.5 mclk = ~mclk;
	rmg_readout_ctrl i_dut (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.trigger_pin   (trigger_pin),
		.restart_done  (restart_done),
		.frame_done    (frame_done),
		.all_rows_int  (all_rows_int),
		.row_valid     (row_valid),
		.row_period    (row_period),
		.pix_row_odd   (pix_row_odd),
		.pix_col_odd   (pix_col_odd),
		.capture_start (capture_start),
		.capture_busy  (capture_busy),
		.frame_restart (frame_restart),
		.col_skip4     (col_skip4),
		.col_skip8     (col_skip8),
		.row_skip4     (row_skip4),
		.row_skip8     (row_skip8),
		.flash_strobe  (flash_strobe),
		.pix_gain      (pix_gain)
	);
	rmg_core_model i_core (
		.mclk          (mclk),
		.capture_start (capture_start),
		.frame_restart (frame_restart),
		.restart_done  (restart_done),
		.frame_done    (frame_done)
	);
	// a hang ends the run as a failure
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			finish_test;
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : cyc
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// leading idle cycle keeps strobes from being set twice in one step
	task wr(input logic [7:0] a, input logic [15:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		cyc(1);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		d = reg_rdata;
	endtask : rd
	task count(input bit sel, input int n, output int k);
		k = 0;
		repeat (n) begin
			k += sel ? capture_start : flash_strobe;
			cyc(1);
		end
	endtask : count
	function automatic logic [7:0] eighths(input logic [6:0] c);
		if (c[6] && c[5]) return {1'b0, 4'h8 + c[2:0], 3'h0};
		return (c[6] ? 8'h02 : 8'h01) * 8'(c[5:0]);
	endfunction : eighths
	task t_regs;
		logic [15:0] d;
		rd(RMG_ADDR_READ_CTL, d);
		chk("ctl reset", d, 16'h8000);
		rd(8'h2b, d);
		chk("gain ee reset", d, 16'h0008);
		rd(8'h2c, d);
		chk("gain oe reset", d, 16'h0008);
		chk("gain out", {8'h00, pix_gain}, 16'h0008);
		rd(8'h77, d);
		chk("unmapped", d, 16'h0000);
		$display("regs done");
	endtask : t_regs
	task t_skip;
		for (int b = 2; b < 6; b++) begin
			wr(RMG_ADDR_READ_CTL, 16'h8000 | (16'h0001 << b));
			cyc(1);
			chk("skips", {12'h000, row_skip8, col_skip8, row_skip4, col_skip4}, 16'h0001 << (b - 2));
		end
		$display("skip done");
	endtask : t_skip
	task automatic t_gain;
		logic [6:0] code [4] = '{7'h10, 7'h51, 7'h61, 7'h20};
		logic [7:0] adr [4] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e};
		logic [15:0] d;
		for (int i = 0; i < 4; i++) wr(adr[i], {9'h000, code[i]});
		for (int i = 0; i < 4; i++) begin
			pix_row_odd = i[0];
			pix_col_odd = i[1];
			cyc(2);
			chk("group gain", {8'h00, pix_gain}, {8'h00, eighths(code[i])});
		end
		wr(RMG_ADDR_GAIN_ALL, 16'h0067);
		rd(8'h2c, d);
		chk("global gain", d, 16'h0067);
		rd(RMG_ADDR_GAIN_ALL, d);
		chk("global readback", d, 16'h0067);
		chk("global out", {8'h00, pix_gain}, 16'h0078);
		$display("gain done");
	endtask : t_gain
	task t_snap;
		int k;
		wr(RMG_ADDR_READ_CTL, 16'h8100);
		cyc(10);
		count(1, 20, k);
		chk("no trigger", 16'(k), 16'h0000);
		trigger_pin = 1;
		count(1, 20, k);
		chk("pin trigger", 16'(k), 16'h0001);
		trigger_pin = 0;
		wr(RMG_ADDR_RESTART, 16'h0001);
		chk("restart set", {15'h0000, frame_restart}, 16'h0001);
		count(1, 20, k);
		chk("reg trigger", 16'(k), 16'h0001);
		chk("restart clear", {15'h0000, frame_restart}, 16'h0000);
		$display("snap done");
	endtask : t_snap
	task t_flash;
		int k, k2;
		wr(RMG_ADDR_READ_CTL, 16'h8200);
		all_rows_int = 1;
		count(0, 12, k);
		all_rows_int = 0;
		chk("narrow", 16'(k), 16'h0004);
		cyc(1);
		all_rows_int = 1;
		cyc(2);
		row_valid = 1;
		count(0, 8, k);
		chk("row valid cut", 16'(k), 16'h0001);
		{all_rows_int, row_valid} = 2'b00;
		wr(RMG_ADDR_READ_CTL, 16'h8600);
		all_rows_int = 1;
		count(0, 10, k);
		all_rows_int = 0;
		count(0, 5, k2);
		chk("wide", 16'(k + k2), 16'h000a);
		wr(RMG_ADDR_READ_CTL, 16'h8800);
		cyc(1);
		chk("override", {15'h0000, flash_strobe}, 16'h0001);
		wr(RMG_ADDR_READ_CTL, 16'h8000);
		cyc(1); // the override level still stands for the clock after the write
		all_rows_int = 1;
		count(0, 8, k);
		chk("disabled", 16'(k), 16'h0000);
		$display("flash done");
	endtask : t_flash
	task finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	initial begin
		cyc(2);
		sys_rst = 0;
		t_regs;
		t_skip;
		t_gain;
		t_snap;
		t_flash;
		finish_test;
	end
endmodule : tb

// file: hw/rmg_readout_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - column skip-by-4 at bit 2, skip-by-8 at bit 4, both reset disabled
// - row skip-by-4 at bit 3, skip-by-8 at bit 5, both reset disabled
// - bit 8 selects snapshot capture; reset value gives continuous capture
// - snapshot trigger comes from the trigger pin or a restart write
// - bit 9 enables flash pulse during all-rows-integrating interval, else none unless bit 11 is set
// - bit 10 low gives one-row flash pulse, cut the clock after row valid rises if sooner
// - bit 10 high stretches flash pulse over whole all-rows-integrating interval
// - bit 11 override forces the flash output high, whatever bits 9 and 10 hold
// - reserved bits reset to zero except bit 15 which resets high
// - separate gain per row/column parity group of pixels
// - gain up to 8 is (bit6+1) times bits 5:0 times 0.125
// - bits 6 and 5 both set give gain 8 plus bits 2:0
// - even-row even-column gain at 0x2b, reset 0x08
// - odd-row even-column gain at 0x2c, reset 0x08
// - restart register clears itself once the restart has happened
// - global gain write loads all four group gains
module rmg_readout_ctrl
	import rmg_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	input  wire logic [7:0]                reg_addr,
	input  wire logic [15:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [15:0]               reg_rdata,
	input  wire logic                      trigger_pin,
	input  wire logic                      restart_done,
	input  wire logic                      frame_done,
	input  wire logic                      all_rows_int,
	input  wire logic                      row_valid,
	input  wire logic [15:0]               row_period,
	input  wire logic                      pix_row_odd,
	input  wire logic                      pix_col_odd,
	output logic                           capture_start,
	output logic                           capture_busy,
	output logic                           frame_restart,
	output logic                           col_skip4,
	output logic                           col_skip8,
	output logic                           row_skip4,
	output logic                           row_skip8,
	output logic                           flash_strobe,
	output logic      [RMG_GAIN_OUT_W-1:0] pix_gain
);

	// gain in eighths: 8 means unity
	// bit 6 with bit 5 leaves the doubling behind and steps in whole units above eight
	function automatic logic [RMG_GAIN_OUT_W-1:0] rmg_gain_eighths(input logic [RMG_GAIN_W-1:0] code);
		logic [3:0] whole;
		whole = RMG_GAIN_HIGH_BASE + {1'b0, code[2:0]};
		if (code[6] && code[5])
			rmg_gain_eighths = {1'b0, whole, 3'b000};
		else if (code[6])
			rmg_gain_eighths = {1'b0, code[5:0], 1'b0};
		else
			rmg_gain_eighths = {2'b00, code[5:0]};
	endfunction : rmg_gain_eighths

	logic [15:0]           read_ctl;
	logic [15:0]           next_read_ctl;
	logic                  restart_req;
	logic                  next_restart_req;
	logic [RMG_GAIN_W-1:0] gain_ee;
	logic [RMG_GAIN_W-1:0] next_gain_ee;
	logic [RMG_GAIN_W-1:0] gain_oe;
	logic [RMG_GAIN_W-1:0] next_gain_oe;
	logic [RMG_GAIN_W-1:0] gain_eo;
	logic [RMG_GAIN_W-1:0] next_gain_eo;
	logic [RMG_GAIN_W-1:0] gain_oo;
	logic [RMG_GAIN_W-1:0] next_gain_oo;
	logic [RMG_GAIN_W-1:0] gain_all;
	logic [RMG_GAIN_W-1:0] next_gain_all;
	logic [15:0]           next_reg_rdata;
	logic                  restart_wr;

	// only a one in bit 0 requests a restart; any other write to that address is dropped
	assign restart_wr = reg_wr && (reg_addr == RMG_ADDR_RESTART) && reg_wdata[RMG_BIT_RESTART];

	// register file next values; control-word reserved bits are stored as written so reads echo them
	always_comb begin
		next_read_ctl = read_ctl;
		next_gain_ee = gain_ee;
		next_gain_oe = gain_oe;
		next_gain_eo = gain_eo;
		next_gain_oo = gain_oo;
		next_gain_all = gain_all;
		// set wins over the self-clear so a fresh request is never dropped
		next_restart_req = (restart_req && !restart_done) || restart_wr;
		// unmapped addresses fall through and change nothing
		if (reg_wr) begin
			unique case (reg_addr)
				RMG_ADDR_READ_CTL: next_read_ctl = reg_wdata;
				RMG_ADDR_GAIN_EE: next_gain_ee = reg_wdata[RMG_GAIN_W-1:0];
				RMG_ADDR_GAIN_OE: next_gain_oe = reg_wdata[RMG_GAIN_W-1:0];
				RMG_ADDR_GAIN_EO: next_gain_eo = reg_wdata[RMG_GAIN_W-1:0];
				RMG_ADDR_GAIN_OO: next_gain_oo = reg_wdata[RMG_GAIN_W-1:0];
				RMG_ADDR_GAIN_ALL: begin
					next_gain_all = reg_wdata[RMG_GAIN_W-1:0];
					next_gain_ee = reg_wdata[RMG_GAIN_W-1:0];
					next_gain_oe = reg_wdata[RMG_GAIN_W-1:0];
					next_gain_eo = reg_wdata[RMG_GAIN_W-1:0];
					next_gain_oo = reg_wdata[RMG_GAIN_W-1:0];
				end
				default: ;
			endcase
		end
		// read data is registered and holds until the next read strobe
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			unique case (reg_addr)
				RMG_ADDR_RESTART: next_reg_rdata = {15'h0000, restart_req};
				RMG_ADDR_READ_CTL: next_reg_rdata = read_ctl;
				RMG_ADDR_GAIN_EE: next_reg_rdata = {9'h000, gain_ee};
				RMG_ADDR_GAIN_OE: next_reg_rdata = {9'h000, gain_oe};
				RMG_ADDR_GAIN_EO: next_reg_rdata = {9'h000, gain_eo};
				RMG_ADDR_GAIN_OO: next_reg_rdata = {9'h000, gain_oo};
				RMG_ADDR_GAIN_ALL: next_reg_rdata = {9'h000, gain_all};
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	// register file storage
	// gains reset to unity; the control word resets with only bit 15 high
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_ctl <= RMG_READ_CTL_RESET;
			restart_req <= 1'b0;
			gain_ee <= RMG_GAIN_RESET;
			gain_oe <= RMG_GAIN_RESET;
			gain_eo <= RMG_GAIN_RESET;
			gain_oo <= RMG_GAIN_RESET;
			gain_all <= RMG_GAIN_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			read_ctl <= next_read_ctl;
			restart_req <= next_restart_req;
			gain_ee <= next_gain_ee;
			gain_oe <= next_gain_oe;
			gain_eo <= next_gain_eo;
			gain_oo <= next_gain_oo;
			gain_all <= next_gain_all;
			reg_rdata <= next_reg_rdata;
		end
	end

	// trigger pin: three stages, a change counts once stages two and three agree
	// so a pin edge reaches capture start about four clocks later; pulses under two clocks may vanish
	logic [2:0] trig_sync;
	logic [2:0] next_trig_sync;
	logic       trig_level;
	logic       next_trig_level;
	logic       trig_rise;

	always_comb begin
		next_trig_sync = {trig_sync[1:0], trigger_pin};
		next_trig_level = (trig_sync[1] == trig_sync[2]) ? trig_sync[2] : trig_level;
		trig_rise = next_trig_level && !trig_level;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			trig_sync <= 3'b000;
			trig_level <= 1'b0;
		end else begin
			trig_sync <= next_trig_sync;
			trig_level <= next_trig_level;
		end
	end

	// capture sequencer; triggers arriving while busy are ignored by design
	// in continuous mode a restart write only raises the pending flag, it starts nothing
	rmg_state_t state;
	rmg_state_t next_state;
	logic       snapshot;
	logic       trig_any;

	assign snapshot = read_ctl[RMG_BIT_SNAPSHOT];
	assign trig_any = trig_rise || restart_wr;

	always_comb begin
		next_state = state;
		unique case (state)
			RMG_ST_IDLE: begin
				if (!snapshot || trig_any)
					next_state = RMG_ST_START;
			end
			RMG_ST_START: next_state = RMG_ST_BUSY;
			RMG_ST_BUSY: begin
				if (frame_done)
					next_state = RMG_ST_IDLE;
			end
			default: next_state = RMG_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			state <= RMG_ST_IDLE;
		else
			state <= next_state;
	end

	// start and busy decode straight from the state register, so no input glitch reaches them
	assign capture_start = (state == RMG_ST_START);
	assign capture_busy = (state != RMG_ST_IDLE);
	assign frame_restart = restart_req;

	// flash pulse: narrow form counts one row from the start of all-rows integration
	logic [15:0] strobe_cnt;
	logic [15:0] next_strobe_cnt;
	logic        int_d;
	logic        next_int_d;
	logic        strobe_narrow;
	logic        next_strobe_narrow;
	logic        next_flash_strobe;
	logic        strobe_logic;

	always_comb begin
		next_int_d = all_rows_int;
		next_strobe_cnt = strobe_cnt;
		next_strobe_narrow = strobe_narrow;
		if (all_rows_int && !int_d) begin
			// a zero row period, or a row already valid at the rise, gives no narrow pulse
			next_strobe_narrow = (row_period != 16'h0000) && !row_valid;
			next_strobe_cnt = row_period;
		end else if (strobe_narrow) begin
			next_strobe_cnt = strobe_cnt - 16'h0001;
			// a rising row valid always ends the pulse, even if the row count is long
			if (strobe_cnt <= 16'h0001 || row_valid || !all_rows_int)
				next_strobe_narrow = 1'b0;
		end
		// wide form simply follows the integrating level, one clock late
		if (read_ctl[RMG_BIT_STROBE_WIDE])
			strobe_logic = all_rows_int;
		else
			strobe_logic = next_strobe_narrow;
		// the override wins over the enable; the host is expected to clear the enable first
		if (read_ctl[RMG_BIT_STROBE_OVR])
			next_flash_strobe = 1'b1;
		else
			next_flash_strobe = read_ctl[RMG_BIT_STROBE_EN] && strobe_logic;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			strobe_cnt <= 16'h0000;
			strobe_narrow <= 1'b0;
			int_d <= 1'b0;
			flash_strobe <= 1'b0;
		end else begin
			strobe_cnt <= next_strobe_cnt;
			strobe_narrow <= next_strobe_narrow;
			int_d <= next_int_d;
			flash_strobe <= next_flash_strobe;
		end
	end

	// skip enables and per-parity pixel gain, registered
	// the skip copies lag the control word by one clock so the readout core sees a clean edge
	logic [RMG_GAIN_OUT_W-1:0] next_pix_gain;
	logic                      next_col_skip4;
	logic                      next_col_skip8;
	logic                      next_row_skip4;
	logic                      next_row_skip8;

	always_comb begin
		next_col_skip4 = read_ctl[RMG_BIT_COL_SKIP4];
		next_col_skip8 = read_ctl[RMG_BIT_COL_SKIP8];
		next_row_skip4 = read_ctl[RMG_BIT_ROW_SKIP4];
		next_row_skip8 = read_ctl[RMG_BIT_ROW_SKIP8];
		// parity is taken one clock before the gain shows on the output
		unique case ({pix_row_odd, pix_col_odd})
			2'b00: next_pix_gain = rmg_gain_eighths(gain_ee);
			2'b10: next_pix_gain = rmg_gain_eighths(gain_oe);
			2'b01: next_pix_gain = rmg_gain_eighths(gain_eo);
			2'b11: next_pix_gain = rmg_gain_eighths(gain_oo);
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pix_gain <= 8'h08;
			col_skip4 <= 1'b0;
			col_skip8 <= 1'b0;
			row_skip4 <= 1'b0;
			row_skip8 <= 1'b0;
		end else begin
			pix_gain <= next_pix_gain;
			col_skip4 <= next_col_skip4;
			col_skip8 <= next_col_skip8;
			row_skip4 <= next_row_skip4;
			row_skip8 <= next_row_skip8;
		end
	end

endmodule : rmg_readout_ctrl

// file: inc/rmg_pkg.sv
package rmg_pkg;
	// register addresses on the configuration port
	localparam logic [7:0] RMG_ADDR_RESTART = 8'h0b;
	localparam logic [7:0] RMG_ADDR_READ_CTL = 8'h1e;
	localparam logic [7:0] RMG_ADDR_GAIN_EE = 8'h2b;
	localparam logic [7:0] RMG_ADDR_GAIN_OE = 8'h2c;
	localparam logic [7:0] RMG_ADDR_GAIN_EO = 8'h2d;
	localparam logic [7:0] RMG_ADDR_GAIN_OO = 8'h2e;
	localparam logic [7:0] RMG_ADDR_GAIN_ALL = 8'h35;
	// read-control and restart field positions
	localparam int RMG_BIT_COL_SKIP4 = 2;
	localparam int RMG_BIT_ROW_SKIP4 = 3;
	localparam int RMG_BIT_COL_SKIP8 = 4;
	localparam int RMG_BIT_ROW_SKIP8 = 5;
	localparam int RMG_BIT_SNAPSHOT = 8;
	localparam int RMG_BIT_STROBE_EN = 9;
	localparam int RMG_BIT_STROBE_WIDE = 10;
	localparam int RMG_BIT_STROBE_OVR = 11;
	localparam int RMG_BIT_RESTART = 0;
	// reset values
	localparam logic [15:0] RMG_READ_CTL_RESET = 16'h8000;
	localparam logic [6:0] RMG_GAIN_RESET = 7'h08;
	// gain code layout
	localparam int RMG_GAIN_W = 7;
	localparam int RMG_GAIN_OUT_W = 8;
	localparam logic [3:0] RMG_GAIN_HIGH_BASE = 4'h8;
	// capture sequencer
	typedef enum logic [1:0] {
		RMG_ST_IDLE = 2'b00,
		RMG_ST_START = 2'b01,
		RMG_ST_BUSY = 2'b10
	} rmg_state_t;
endpackage : rmg_pkg
